// File: rlm_params.svh
/*
 * constants for the reading logger: rates, depths, timing counts.
 * assumes a 25 MHz system clock.
 */
`ifndef RLM_PARAMS_SVH
`define RLM_PARAMS_SVH

`define RLM_CLK_HZ 25000000
`define RLM_DEPTH 100
`define RLM_PTR_W 7
`define RLM_DATA_W 24
`define RLM_FIFO_DEPTH 32
`define RLM_RATE_W 3
`define RLM_RATE_EVERY 3'h0
`define RLM_RATE_MAX_CODE 3'h6
`define RLM_RATE_MANUAL 3'h6
// rate periods in seconds
`define RLM_SEC_1 1
`define RLM_SEC_10 10
`define RLM_SEC_60 60
`define RLM_SEC_600 600
`define RLM_SEC_3600 3600
// min/max sample rate per second
`define RLM_MINMAX_HZ 3
`define RLM_SEC_CYC (`RLM_CLK_HZ)
`define RLM_MINMAX_CYC (`RLM_CLK_HZ / `RLM_MINMAX_HZ)
// hold time per rate code step while scrolling, in ms
`define RLM_SCROLL_MS 500
`define RLM_SCROLL_CYC (`RLM_CLK_HZ / 1000 * `RLM_SCROLL_MS)
// location display time, in ms
`define RLM_SHOW_MS 1000
`define RLM_SHOW_CYC (`RLM_CLK_HZ / 1000 * `RLM_SHOW_MS)
// recall flash half period, in ms
`define RLM_FLASH_MS 250
`define RLM_FLASH_CYC (`RLM_CLK_HZ / 1000 * `RLM_FLASH_MS)

`endif

// File: rlm_pkg.sv
/*
 * types for the reading logger.
 * assumes rlm_params.svh is included by users that need numbers.
 */
package rlm_pkg;
	typedef enum logic [1:0] {
		RLM_IDLE,
		RLM_SCROLL,
		RLM_LOG,
		RLM_SHOW
	} rlm_state_t;
endpackage

// File: rlm_fifo.sv
/*
 * small synchronous fifo, valid/ready on both sides.
 * assumes one clock and synchronous active-high reset.
 */
module rlm_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 32
) (
	input wire logic clk_i, // clock
	input wire logic rst_i, // sync reset
	input wire logic [WIDTH-1:0] in_data_i, // write data
	input wire logic in_valid_i, // write request
	output logic in_ready_o, // not full
	output logic [WIDTH-1:0] out_data_o, // head word
	output logic out_valid_o, // not empty
	input wire logic out_ready_i // head taken
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic wr;
	logic rd;

	// full is the only reason to refuse; an empty fifo must accept
	assign in_ready_o = (32'(cnt_q) < DEPTH);
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o = mem_q[rp_q];
	assign wr = in_valid_i && in_ready_o;
	assign rd = out_valid_o && out_ready_i;

	always_ff @(posedge clk_i) begin
		if (wr) begin
			mem_q[wp_q] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (wr) begin
				wp_q <= (32'(wp_q) == DEPTH - 1) ? '0 : wp_q + 1'b1;
			end
			if (rd) begin
				rp_q <= (32'(rp_q) == DEPTH - 1) ? '0 : rp_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= '0;
		end else if (wr && !rd) begin
			cnt_q <= cnt_q + 1'b1;
		end else if (rd && !wr) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	property p_no_overflow;
		@(posedge clk_i) disable iff (rst_i) 32'(cnt_q) <= DEPTH;
	endproperty
	a_no_overflow: assert property (p_no_overflow) else $error("fifo count above depth");
endmodule

// File: rlm_sync.sv
/*
 * two flip-flop synchroniser for one level.
 * assumes asynchronous input, one clock.
 */
module rlm_sync (
	input wire logic clk_i, // clock
	input wire logic rst_i, // sync reset
	input wire logic d_i, // async level
	output logic q_o // synchronised level
);
	logic meta_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= 1'b0;
			q_o <= 1'b0;
		end else begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule

// File: rlm_logger.sv
/*
 * reading logger with min/max tracking and relative dB zero.
 * buttons come from the front panel (async, synchronised here);
 * readings come from the measurement engine on clk_i as signed words.
 */
// Notes on behaviour
// - hundred-entry buffer plus min and max while logging
// - rate code 0 every conversion, 1..5 timed, 6 manual
// - manual mode: one store per press
// - min/max sampled three times per second
// - hold scrolls rate; release latches, starts logging
// - short press starts logger without rate choice
// - after manual store show location, one-based
// - relative press in dB captures reference, shows zero
// - press while logging stops, data kept; recall+store ends manual
// - recall indicator flashes when buffer full
// - min/max update while logging, even full
`include "rlm_params.svh"

module rlm_logger (
	input wire logic clk_i, // 25 MHz clock
	input wire logic rst_i, // sync reset, active high
	input wire logic store_clear_button_i, // store/clear button, async, high pressed
	input wire logic recall_button_i, // recall button, async, high pressed
	input wire logic relative_zero_control_i, // relative button, async, high pressed
	input wire logic db_mode_i, // dB mode active, same clock
	input wire logic [`RLM_DATA_W-1:0] reading_i, // signed reading, same clock
	input wire logic reading_valid_i, // one-cycle conversion done strobe
	output logic [`RLM_DATA_W-1:0] display_o, // live reading minus reference
	output logic [`RLM_RATE_W-1:0] rate_o, // shown or latched rate code
	output logic show_rate_o, // rate code being scrolled
	output logic show_loc_o, // buffer location being shown
	output logic [`RLM_PTR_W-1:0] loc_o, // one-based location shown
	output logic logging_indicator_o, // store annunciator
	output logic recall_flash_o, // recall annunciator, flashing when full
	output logic [`RLM_DATA_W-1:0] min_o, // lowest reading
	output logic [`RLM_DATA_W-1:0] max_o, // highest reading
	output logic [`RLM_PTR_W-1:0] count_o, // entries stored
	output logic [`RLM_DATA_W-1:0] last_o // last stored reading
);
	// =====================================
	// button synchronisers and edges
	logic sc_s;
	logic rc_s;
	logic rel_s;
	logic sc_prev_q;
	logic rel_prev_q;
	logic sc_rise;
	logic sc_fall;
	logic rel_rise;

	rlm_sync u_sync_sc (.clk_i(clk_i), .rst_i(rst_i), .d_i(store_clear_button_i), .q_o(sc_s));
	rlm_sync u_sync_rc (.clk_i(clk_i), .rst_i(rst_i), .d_i(recall_button_i), .q_o(rc_s));
	rlm_sync u_sync_rel (.clk_i(clk_i), .rst_i(rst_i), .d_i(relative_zero_control_i),
		.q_o(rel_s));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sc_prev_q <= 1'b0;
			rel_prev_q <= 1'b0;
		end else begin
			sc_prev_q <= sc_s;
			rel_prev_q <= rel_s;
		end
	end
	assign sc_rise = sc_s && !sc_prev_q;
	assign sc_fall = !sc_s && sc_prev_q;
	assign rel_rise = rel_s && !rel_prev_q;

	// =====================================
	// control state machine
	rlm_pkg::rlm_state_t state_q;
	logic [`RLM_RATE_W-1:0] rate_q;
	logic [31:0] scroll_cnt_q;
	logic [31:0] show_cnt_q;
	logic manual_store;
	logic full;
	logic stop_req;

	assign full = (32'(count_o) == `RLM_DEPTH);
	// in manual rate a press means "store"; recall held with it ends the cycle
	assign manual_store = (state_q == rlm_pkg::RLM_LOG) && (rate_q == `RLM_RATE_MANUAL)
		&& sc_rise && !rc_s;
	assign stop_req = (state_q == rlm_pkg::RLM_LOG) && sc_rise
		&& ((rate_q != `RLM_RATE_MANUAL) || rc_s);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= rlm_pkg::RLM_IDLE;
			rate_q <= `RLM_RATE_EVERY;
			scroll_cnt_q <= '0;
			show_cnt_q <= '0;
		end else begin
			case (state_q)
				rlm_pkg::RLM_IDLE: begin
					if (sc_rise) begin
						state_q <= rlm_pkg::RLM_SCROLL;
						rate_q <= `RLM_RATE_EVERY;
						scroll_cnt_q <= '0;
					end
				end
				rlm_pkg::RLM_SCROLL: begin
					// short press leaves rate at code 0 and still starts
					if (sc_fall) begin
						state_q <= rlm_pkg::RLM_LOG;
					end else if (scroll_cnt_q == `RLM_SCROLL_CYC - 1) begin
						scroll_cnt_q <= '0;
						rate_q <= (rate_q == `RLM_RATE_MAX_CODE) ? `RLM_RATE_EVERY
							: rate_q + 3'h1;
					end else begin
						scroll_cnt_q <= scroll_cnt_q + 32'h1;
					end
				end
				rlm_pkg::RLM_LOG: begin
					if (stop_req) begin
						state_q <= rlm_pkg::RLM_IDLE;
					end else if (manual_store) begin
						state_q <= rlm_pkg::RLM_SHOW;
						show_cnt_q <= '0;
					end
				end
				rlm_pkg::RLM_SHOW: begin
					if (show_cnt_q == `RLM_SHOW_CYC - 1) begin
						state_q <= rlm_pkg::RLM_LOG;
					end else begin
						show_cnt_q <= show_cnt_q + 32'h1;
					end
				end
				default: state_q <= rlm_pkg::RLM_IDLE;
			endcase
		end
	end

	// =====================================
	// rate tick generation
	logic [31:0] sec_cnt_q;
	logic [11:0] sec_tot_q;
	logic sec_tick;
	logic rate_tick;
	logic active;

	assign active = (state_q == rlm_pkg::RLM_LOG) || (state_q == rlm_pkg::RLM_SHOW);
	assign sec_tick = (sec_cnt_q == `RLM_SEC_CYC - 1);

	always_ff @(posedge clk_i) begin
		if (rst_i || !active) begin
			sec_cnt_q <= '0;
			sec_tot_q <= '0;
		end else if (sec_tick) begin
			sec_cnt_q <= '0;
			sec_tot_q <= (sec_tot_q == 12'(`RLM_SEC_3600 - 1)) ? '0 : sec_tot_q + 12'h1;
		end else begin
			sec_cnt_q <= sec_cnt_q + 32'h1;
		end
	end

	always_comb begin
		case (rate_q)
			3'h0: rate_tick = reading_valid_i;
			3'h1: rate_tick = sec_tick;
			3'h2: rate_tick = sec_tick && (32'(sec_tot_q) % `RLM_SEC_10 == `RLM_SEC_10 - 1);
			3'h3: rate_tick = sec_tick && (32'(sec_tot_q) % `RLM_SEC_60 == `RLM_SEC_60 - 1);
			3'h4: rate_tick = sec_tick && (32'(sec_tot_q) % `RLM_SEC_600 == `RLM_SEC_600 - 1);
			3'h5: rate_tick = sec_tick && (32'(sec_tot_q) == `RLM_SEC_3600 - 1);
			default: rate_tick = manual_store;
		endcase
	end

	// =====================================
	// store path through fifo into the 100-entry buffer
	logic [`RLM_DATA_W-1:0] cur_q;
	logic store_req;
	logic fifo_in_ready;
	logic [`RLM_DATA_W-1:0] fifo_data;
	logic fifo_valid;
	logic buf_ready;
	logic [`RLM_DATA_W-1:0] mem_q [`RLM_DEPTH];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur_q <= '0;
		end else if (reading_valid_i) begin
			cur_q <= reading_i;
		end
	end

	// rate 0 stores the new conversion itself, others the latest one
	assign store_req = (state_q == rlm_pkg::RLM_LOG) && rate_tick && !stop_req;
	assign buf_ready = !full;

	rlm_fifo #(.WIDTH(`RLM_DATA_W), .DEPTH(`RLM_FIFO_DEPTH)) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_data_i((rate_q == `RLM_RATE_EVERY) ? reading_i : cur_q),
		.in_valid_i(store_req),
		.in_ready_o(fifo_in_ready),
		.out_data_o(fifo_data),
		.out_valid_o(fifo_valid),
		.out_ready_i(buf_ready)
	);

	always_ff @(posedge clk_i) begin
		if (fifo_valid && buf_ready) begin
			mem_q[count_o] <= fifo_data;
		end
	end

	// stop at the hundredth entry; excess words drain into the fifo unused
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_o <= '0;
			last_o <= '0;
		end else if (fifo_valid && buf_ready) begin
			count_o <= count_o + 7'h1;
			last_o <= fifo_data;
		end
	end

	// =====================================
	// min/max at three samples per second
	logic [31:0] mm_cnt_q;
	logic mm_seen_q;
	logic mm_tick;

	assign mm_tick = (mm_cnt_q == `RLM_MINMAX_CYC - 1);

	always_ff @(posedge clk_i) begin
		if (rst_i || !active) begin
			mm_cnt_q <= '0;
		end else begin
			mm_cnt_q <= mm_tick ? '0 : mm_cnt_q + 32'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			min_o <= '0;
			max_o <= '0;
			mm_seen_q <= 1'b0;
		end else if (state_q == rlm_pkg::RLM_SCROLL && sc_fall) begin
			mm_seen_q <= 1'b0;
		end else if (active && mm_tick) begin
			mm_seen_q <= 1'b1;
			if (!mm_seen_q || $signed(cur_q) < $signed(min_o)) begin
				min_o <= cur_q;
			end
			if (!mm_seen_q || $signed(cur_q) > $signed(max_o)) begin
				max_o <= cur_q;
			end
		end
	end

	// =====================================
	// relative reference and display
	logic [`RLM_DATA_W-1:0] ref_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ref_q <= '0;
		end else if (rel_rise) begin
			ref_q <= db_mode_i ? cur_q : '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			display_o <= '0;
		end else if (rel_rise && db_mode_i) begin
			display_o <= '0;
		end else begin
			display_o <= cur_q - ref_q;
		end
	end

	// =====================================
	// indicators
	logic [31:0] flash_cnt_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flash_cnt_q <= '0;
			recall_flash_o <= 1'b0;
		end else if (!full) begin
			flash_cnt_q <= '0;
			recall_flash_o <= 1'b0;
		end else if (flash_cnt_q == `RLM_FLASH_CYC - 1) begin
			flash_cnt_q <= '0;
			recall_flash_o <= !recall_flash_o;
		end else begin
			flash_cnt_q <= flash_cnt_q + 32'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			logging_indicator_o <= 1'b0;
			show_rate_o <= 1'b0;
			show_loc_o <= 1'b0;
			rate_o <= '0;
			loc_o <= '0;
		end else begin
			logging_indicator_o <= active;
			show_rate_o <= (state_q == rlm_pkg::RLM_SCROLL);
			show_loc_o <= (state_q == rlm_pkg::RLM_SHOW);
			rate_o <= rate_q;
			loc_o <= count_o;
		end
	end

	// =====================================
	// checks
	property p_full_stops;
		@(posedge clk_i) disable iff (rst_i) full |=> $stable(count_o);
	endproperty
	a_full_stops: assert property (p_full_stops) else $error("count moved when full");

	property p_count_max;
		@(posedge clk_i) disable iff (rst_i) 32'(count_o) <= `RLM_DEPTH;
	endproperty
	a_count_max: assert property (p_count_max) else $error("count above depth");

	property p_manual_one;
		@(posedge clk_i) disable iff (rst_i) store_req && rate_q == `RLM_RATE_MANUAL
			|-> manual_store;
	endproperty
	a_manual_one: assert property (p_manual_one) else $error("manual store without press");

	property p_release_logs;
		@(posedge clk_i) disable iff (rst_i) state_q == rlm_pkg::RLM_SCROLL && sc_fall
			|=> ##1 logging_indicator_o;
	endproperty
	a_release_logs: assert property (p_release_logs) else $error("no logging after release");

	property p_stop;
		@(posedge clk_i) disable iff (rst_i) stop_req |=> ##1 !logging_indicator_o
			&& $stable(count_o);
	endproperty
	a_stop: assert property (p_stop) else $error("stop misbehaved");

	property p_rel_zero;
		@(posedge clk_i) disable iff (rst_i) rel_rise && db_mode_i |=> display_o == '0;
	endproperty
	a_rel_zero: assert property (p_rel_zero) else $error("display not zero after rel");

	property p_mm_hold;
		@(posedge clk_i) disable iff (rst_i) !active && !(state_q == rlm_pkg::RLM_SCROLL)
			|=> $stable(min_o) && $stable(max_o);
	endproperty
	a_mm_hold: assert property (p_mm_hold) else $error("min/max moved while off");

	property p_mm_order;
		@(posedge clk_i) disable iff (rst_i) mm_seen_q |-> $signed(min_o) <= $signed(max_o);
	endproperty
	a_mm_order: assert property (p_mm_order) else $error("min above max");

	property p_show_loc;
		@(posedge clk_i) disable iff (rst_i) manual_store && !full ##1 1 |-> ##2
			show_loc_o && 32'(loc_o) >= 1;
	endproperty
	a_show_loc: assert property (p_show_loc) else $error("location not shown");

	c_full: cover property (@(posedge clk_i) disable iff (rst_i) full);
	c_manual: cover property (@(posedge clk_i) disable iff (rst_i) manual_store);
	c_rel: cover property (@(posedge clk_i) disable iff (rst_i) rel_rise && db_mode_i);
	c_stop: cover property (@(posedge clk_i) disable iff (rst_i) stop_req);
endmodule

// File: rlm_panel_model.sv
/*
 * front panel and measurement source model for the reading logger.
 * assumes it shares the bench clock and that every call starts just after a rising edge.
 */
`include "rlm_params.svh"

module rlm_panel_model (
	input wire logic clk_i, // bench clock
	output logic store_clear_button_o, // high while pressed
	output logic recall_button_o, // high while pressed
	output logic relative_zero_control_o, // high while pressed
	output logic db_mode_o, // dB mode level
	output logic [`RLM_DATA_W-1:0] reading_o, // reading word
	output logic reading_valid_o // one-cycle conversion strobe
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		store_clear_button_o = 1'b0;
		recall_button_o = 1'b0;
		relative_zero_control_o = 1'b0;
		db_mode_o = 1'b0;
		reading_o = 24'h000000;
		reading_valid_o = 1'b0;
	end

	// =========================================================
	// operator: hold and release, several edges per level
	task buttons(input logic s, input logic r, input logic z);
		@(posedge clk_i);
		store_clear_button_o <= s;
		recall_button_o <= r;
		relative_zero_control_o <= z;
	endtask

	task set_db(input logic m);
		@(posedge clk_i);
		db_mode_o <= m;
	endtask

	// =========================================================
	// engine: word is scrambled after the strobe so stale data never matches
	task send(input logic [`RLM_DATA_W-1:0] v);
		@(posedge clk_i);
		reading_o <= v;
		reading_valid_o <= 1'b1;
		@(posedge clk_i);
		reading_o <= ~v;
		reading_valid_o <= 1'b0;
	endtask
endmodule

// File: reading_logger_minmax_tb_top.sv
/*
 * self-checking bench for the reading logger with a panel and engine model.
 * assumes the 25 MHz timing macros; scroll, min/max and flash periods are
 * millions of cycles, so only their idle levels are checked here.
 */
`include "rlm_params.svh"

module reading_logger_minmax_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk_i;
	logic rst_i = 1'b1;
	logic sc, rc, rz, dbm, rv;
	logic [23:0] rd, disp, mn, mx, last;
	logic [2:0] rate;
	logic show_rate, show_loc, ind, flash;
	logic [6:0] loc, count;
	int err_count = 0;
	int cmp_count = 0;

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	rlm_panel_model pm (.clk_i(clk_i), .store_clear_button_o(sc), .recall_button_o(rc),
		.relative_zero_control_o(rz), .db_mode_o(dbm), .reading_o(rd), .reading_valid_o(rv));

	rlm_logger uut (.clk_i(clk_i), .rst_i(rst_i), .store_clear_button_i(sc),
		.recall_button_i(rc), .relative_zero_control_i(rz), .db_mode_i(dbm),
		.reading_i(rd), .reading_valid_i(rv), .display_o(disp), .rate_o(rate),
		.show_rate_o(show_rate), .show_loc_o(show_loc), .loc_o(loc),
		.logging_indicator_o(ind), .recall_flash_o(flash), .min_o(mn), .max_o(mx),
		.count_o(count), .last_o(last));

	// =========================================================
	// compare and report
	task chk_val(input logic [23:0] got, input logic [23:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task chk_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task wait_ind(input logic lvl);
		int n;
		n = 0;
		while (ind !== lvl && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		chk_bit(ind, lvl);
	endtask

	task summarize();
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// =========================================================
	// scenarios
	task t_reset();
		chk_val({17'h0, count}, 24'h000000);
		chk_bit(ind, 1'b0);
		chk_bit(show_rate, 1'b0);
		chk_bit(show_loc, 1'b0);
		chk_bit(flash, 1'b0);
		chk_val(mn, 24'h000000);
		chk_val(mx, 24'h000000);
		$display("t_reset done");
	endtask

	// short press: released long before the first scroll step
	task t_start();
		pm.buttons(1'b1, 1'b0, 1'b0);
		repeat (8) @(posedge clk_i);
		chk_bit(show_rate, 1'b1);
		chk_bit(ind, 1'b0);
		pm.buttons(1'b0, 1'b0, 1'b0);
		wait_ind(1'b1);
		chk_val({21'h0, rate}, 24'h000000);
		chk_bit(show_rate, 1'b0);
		$display("t_start done");
	endtask

	// rate 0: every conversion stored, five beyond a full buffer
	task t_fill();
		logic [23:0] exp;
		for (int i = 1; i <= 105; i++) begin
			pm.send(24'h000100 + 24'(i));
			repeat (6) @(posedge clk_i);
			exp = (i > 100) ? 24'd100 : 24'(i);
			chk_val({17'h0, count}, exp);
			chk_val({17'h0, loc}, exp);
			if (i < 100) chk_bit(flash, 1'b0);
		end
		chk_val(last, 24'h000164);
		$display("t_fill done");
	endtask

	// stop press, optionally with recall held (non-manual rate still stops); later readings ignored
	task t_stop(input logic r, input logic [23:0] exp_cnt, input logic [23:0] exp_last);
		pm.buttons(1'b1, r, 1'b0);
		repeat (8) @(posedge clk_i);
		pm.buttons(1'b0, 1'b0, 1'b0);
		wait_ind(1'b0);
		pm.send(24'h000777);
		repeat (6) @(posedge clk_i);
		chk_val({17'h0, count}, exp_cnt);
		chk_val(last, exp_last);
		$display("t_stop done");
	endtask

	task t_rel();
		pm.set_db(1'b1);
		pm.send(24'h000050);
		repeat (4) @(posedge clk_i);
		pm.buttons(1'b0, 1'b0, 1'b1);
		repeat (8) @(posedge clk_i);
		pm.buttons(1'b0, 1'b0, 1'b0);
		chk_val(disp, 24'h000000);
		pm.send(24'h000058);
		repeat (4) @(posedge clk_i);
		chk_val(disp, 24'h000008);
		// outside dB mode a press drops the reference
		pm.set_db(1'b0);
		pm.buttons(1'b0, 1'b0, 1'b1);
		repeat (8) @(posedge clk_i);
		pm.buttons(1'b0, 1'b0, 1'b0);
		pm.send(24'h000058);
		repeat (4) @(posedge clk_i);
		chk_val(disp, 24'h000058);
		$display("t_rel done");
	endtask

	// =========================================================
	// sequence and watchdog
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		t_reset();
		t_start();
		t_stop(1'b0, 24'h000000, 24'h000000);
		t_start();
		t_fill();
		t_stop(1'b1, 24'd100, 24'h000164);
		t_rel();
		summarize();
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		$display("watchdog expired");
		summarize();
	end
endmodule
